/* smeis_pkg.sv */
// How it works
// - a decode error on a descriptor fetch sets status bit 10.
// - that error stops the channel by forcing run_stop to 0.
// - once run_stop is 0 and the engine has fully shut down, the halted flag reads 1.
// - the error loads the current descriptor pointer with the failing descriptor's address.
// - with several errors every flag is kept but the pointer holds only the first address.
// - the decode error stays set until a soft or hard reset, which software must issue.
// - the decode error is never written back into a descriptor, only into the status register.
// - without descriptor support the decode error bit is unused and reads 0.
// - status bit 11 always reads 0 and writes to it do nothing.
// - in descriptor mode, finishing a descriptor with its end-of-frame mark sets bit 12.
// - in simple mode, finishing a packet sets bit 12.
// - a completion drives the interrupt only when its enable is 1 and the threshold is met.
// - writing 1 to a write-to-clear flag clears it; writing 0 leaves it alone.
package smeis_pkg;

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CUR_DESC = 8'h08;

   // ------------------------------------------------------------
   // channel_control fields
   // ------------------------------------------------------------
   localparam int CTL_RUN_STOP = 0;
   localparam int CTL_SOFT_RESET = 2;
   localparam int CTL_IOC_ENABLE = 12;
   localparam int CTL_THRESH_LSB = 16;
   localparam logic [7:0] THRESH_RESET = 8'h01;

   // ------------------------------------------------------------
   // channel_status fields
   // ------------------------------------------------------------
   localparam int STS_HALTED = 0;
   localparam int STS_IDLE = 1;
   localparam int STS_DEC_ERR = 10;
   localparam int STS_RSVD11 = 11;
   localparam int STS_IOC = 12;
   localparam int STS_COUNT_LSB = 16;

   // descriptor pointers are 64-byte aligned, low bits read as zero
   localparam int DESC_ALIGN = 6;
   localparam logic [DATA_W-1:0] DESC_MASK = 32'hFFFFFFC0;

   typedef enum logic [1:0] {
      ST_HALTED = 2'b00,
      ST_RUNNING = 2'b01,
      ST_STOPPING = 2'b11
   } smeis_state_type;

endpackage

/* smeis_sticky_flag.sv */
`timescale 1ns/1ns
// sticky status bit: a set in the same cycle as a clear wins
module smeis_sticky_flag (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic set_i,
   input wire logic clear_i,
   // state
   output logic flag_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

/* smeis_status.sv */
`timescale 1ns/1ns
module smeis_status #(
   parameter bit DESC_MODE = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [smeis_pkg::ADDR_W-1:0] addr_i,
   input wire logic [smeis_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [smeis_pkg::DATA_W-1:0] rd_data_o,
   // descriptor fetch path
   input wire logic fetch_dec_err_i,
   input wire logic [smeis_pkg::DATA_W-1:0] fetch_err_addr_i,
   // transfer path
   input wire logic engine_idle_i,
   input wire logic desc_done_i,
   input wire logic desc_eof_i,
   input wire logic packet_done_i,
   // channel outputs
   output logic run_stop_o,
   output logic halted_o,
   output logic soft_reset_o,
   output logic [smeis_pkg::DATA_W-1:0] cur_desc_o,
   output logic irq_o
);
   import smeis_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   smeis_state_type state;
   smeis_state_type next_state;
   logic [7:0] thresh;
   logic [7:0] ioc_count;
   logic ioc_enable;
   logic dec_err;
   logic ioc_flag;
   logic clr_all;
   logic wr_ctl;
   logic wr_sts;
   logic dec_err_event;
   logic ioc_event;
   logic ioc_clear;
   logic thresh_met;
   logic [DATA_W-1:0] ctl_word;
   logic [DATA_W-1:0] sts_word;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign wr_ctl = wr_i && (addr_i == OFS_CONTROL);
   assign wr_sts = wr_i && (addr_i == OFS_STATUS);
   // soft reset acts one cycle after its write, same as a hard reset
   assign clr_all = rst_i || soft_reset_o;
   // the error input is ignored entirely without descriptor support
   assign dec_err_event = DESC_MODE && fetch_dec_err_i;
   assign ioc_event = DESC_MODE ? (desc_done_i && desc_eof_i)
                                : packet_done_i;
   assign ioc_clear = wr_sts && wr_data_i[STS_IOC];
   assign thresh_met = (ioc_count >= thresh);

   // ------------------------------------------------------------
   // soft reset pulse
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= wr_ctl && wr_data_i[CTL_SOFT_RESET];
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         run_stop_o <= 1'b0;
         ioc_enable <= 1'b0;
         thresh <= THRESH_RESET;
      end else begin
         if (wr_ctl) begin
            ioc_enable <= wr_data_i[CTL_IOC_ENABLE];
            // a zero threshold would always be met; keep the old value
            if (wr_data_i[CTL_THRESH_LSB +: 8] != 8'h00) begin
               thresh <= wr_data_i[CTL_THRESH_LSB +: 8];
            end
         end
         // the error overrides a start written in the same cycle
         if (dec_err_event || dec_err) begin
            run_stop_o <= 1'b0;
         end else if (wr_ctl) begin
            run_stop_o <= wr_data_i[CTL_RUN_STOP];
         end
      end
   end

   // ------------------------------------------------------------
   // halt sequence
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_HALTED: begin
            if (run_stop_o) begin
               next_state = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (!run_stop_o) begin
               next_state = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            // a restart while draining goes back to running, never through halted
            if (run_stop_o) begin
               next_state = ST_RUNNING;
            end else if (engine_idle_i) begin
               // halted only once the engine has drained completely
               next_state = ST_HALTED;
            end
         end
         default: begin
            next_state = ST_HALTED;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         state <= ST_HALTED;
         halted_o <= 1'b1;
      end else begin
         state <= next_state;
         halted_o <= (next_state == ST_HALTED);
      end
   end

   // ------------------------------------------------------------
   // sticky flags
   // ------------------------------------------------------------
   // the decode error has no software clear: only reset removes it
   smeis_sticky_flag u_dec_err (
      .clk_i(clk_i),
      .rst_i(clr_all),
      .set_i(dec_err_event),
      .clear_i(1'b0),
      .flag_o(dec_err)
   );

   smeis_sticky_flag u_ioc_flag (
      .clk_i(clk_i),
      .rst_i(clr_all),
      .set_i(ioc_event),
      .clear_i(ioc_clear),
      .flag_o(ioc_flag)
   );

   // ------------------------------------------------------------
   // completion threshold count
   // ------------------------------------------------------------
   // counts completions since the flag was last cleared; saturates
   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         ioc_count <= 8'h00;
      end else if (ioc_clear) begin
         ioc_count <= ioc_event ? 8'h01 : 8'h00;
      end else if (ioc_event && ioc_count != 8'hFF) begin
         ioc_count <= ioc_count + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // current descriptor pointer
   // ------------------------------------------------------------
   // only the first failing address is kept, later ones would hide the cause
   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         cur_desc_o <= '0;
      end else if (dec_err_event && !dec_err) begin
         cur_desc_o <= fetch_err_addr_i & DESC_MASK;
      end else if (wr_i && addr_i == OFS_CUR_DESC && state == ST_HALTED && !dec_err) begin
         cur_desc_o <= wr_data_i & DESC_MASK;
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   // level output; the decode error is reported by status only and
   // never reaches any descriptor write-back path
   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= ioc_enable && ioc_flag && thresh_met && !ioc_clear;
      end
   end

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   always_comb begin
      ctl_word = '0;
      ctl_word[CTL_RUN_STOP] = run_stop_o;
      ctl_word[CTL_IOC_ENABLE] = ioc_enable;
      ctl_word[CTL_THRESH_LSB +: 8] = thresh;
      sts_word = '0;
      sts_word[STS_HALTED] = halted_o;
      sts_word[STS_IDLE] = engine_idle_i;
      sts_word[STS_DEC_ERR] = dec_err;
      sts_word[STS_RSVD11] = 1'b0;
      sts_word[STS_IOC] = ioc_flag;
      sts_word[STS_COUNT_LSB +: 8] = ioc_count;
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || !rd_i) begin
         rd_data_o <= '0;
      end else begin
         case (addr_i)
            OFS_CONTROL: begin
               rd_data_o <= ctl_word;
            end
            OFS_STATUS: begin
               rd_data_o <= sts_word;
            end
            OFS_CUR_DESC: begin
               rd_data_o <= cur_desc_o;
            end
            default: begin
               rd_data_o <= '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_dec_err_hit;
      !clr_all && dec_err_event;
   endsequence

   sequence s_stopped_and_idle;
      !clr_all && state == ST_STOPPING && engine_idle_i && !run_stop_o && !wr_ctl;
   endsequence

   a_dec_err_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_dec_err_hit |=> dec_err)
      else $error("decode error flag not set");

   a_halt_forced: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_dec_err_hit |=> !run_stop_o [*3])
      else $error("run_stop not forced low on decode error");

   a_halted_after: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_stopped_and_idle |=> halted_o && !run_stop_o)
      else $error("halted flag missing after shutdown");

   a_halted_only_stopped: assert property (
      @(posedge clk_i) disable iff (rst_i)
      halted_o |-> !$past(run_stop_o) || $past(clr_all))
      else $error("halted while running");

   a_ptr_loaded: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_dec_err_hit ##0 !dec_err |=> cur_desc_o == ($past(fetch_err_addr_i) & DESC_MASK))
      else $error("pointer not loaded with errored address");

   a_ptr_one_addr: assert property (
      @(posedge clk_i) disable iff (rst_i)
      dec_err && !soft_reset_o |=> $stable(cur_desc_o))
      else $error("pointer changed after first error");

   a_err_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      dec_err && !soft_reset_o |=> dec_err)
      else $error("decode error cleared without reset");

   a_simple_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !DESC_MODE |-> !dec_err)
      else $error("decode error set in simple mode");

   a_bit11_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rd_i && addr_i == OFS_STATUS |=> rd_data_o[STS_RSVD11] == 1'b0)
      else $error("reserved bit 11 read nonzero");

   a_ioc_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !clr_all && (DESC_MODE ? desc_done_i && desc_eof_i : packet_done_i) |=> ioc_flag)
      else $error("completion flag not set");

   a_ioc_needs_cause: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(ioc_flag) |-> $past(DESC_MODE ? desc_done_i && desc_eof_i : packet_done_i))
      else $error("completion flag set without completion");

   a_irq_gated: assert property (
      @(posedge clk_i) disable iff (rst_i)
      irq_o |-> $past(ioc_enable) && $past(thresh_met) && $past(ioc_flag))
      else $error("interrupt without enable or threshold");

   a_wc_clear: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !clr_all && ioc_clear && !ioc_event |=> !ioc_flag)
      else $error("write of one did not clear flag");

   a_wc_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !clr_all && wr_sts && !wr_data_i[STS_IOC] && ioc_flag |=> ioc_flag)
      else $error("write of zero cleared flag");

   a_irq_level: assert property (
      @(posedge clk_i) disable iff (rst_i)
      irq_o && ioc_enable && !ioc_clear && !clr_all && !wr_ctl && !$past(wr_ctl) |=> irq_o [*1])
      else $error("interrupt dropped while flag set");

   a_irq_drops: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !clr_all && ioc_clear && !ioc_event |=> !irq_o ##1 !irq_o)
      else $error("interrupt held after clear");

   a_run_refused: assert property (
      @(posedge clk_i) disable iff (rst_i)
      dec_err && !clr_all |=> !run_stop_o)
      else $error("run_stop set while decode error held");

   sequence s_soft_write;
      !clr_all && wr_ctl && wr_data_i[CTL_SOFT_RESET];
   endsequence

   a_soft_clears: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_soft_write |=> soft_reset_o ##1 !soft_reset_o && !dec_err)
      else $error("soft reset did not clear decode error");

   a_ptr_masked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cur_desc_o[DESC_ALIGN-1:0] == 6'h00)
      else $error("pointer low bits not zero");

endmodule

/* smeis_status_tb.sv */
`timescale 1ns/1ns
module smeis_status_tb;
   import smeis_pkg::*;

   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk_i, rst_i, wr_i, rd_i, fetch_dec_err_i, engine_idle_i;
   logic desc_done_i, desc_eof_i, packet_done_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wr_data_i, fetch_err_addr_i, rd_data_o, rd_data_s, cur_desc_o;
   logic [DATA_W-1:0] rd_d, rd_s;
   logic run_stop_o, halted_o, soft_reset_o, irq_o;
   int n_fail = 0;
   int tests_run = 0;

   // ------------------------------------------------------------
   // descriptor-mode instance, plus a simple-mode one on the same inputs
   // ------------------------------------------------------------
   smeis_status #(.DESC_MODE(1'b1)) u_smeis_status (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
      .rd_i(rd_i), .rd_data_o(rd_data_o), .fetch_dec_err_i(fetch_dec_err_i),
      .fetch_err_addr_i(fetch_err_addr_i), .engine_idle_i(engine_idle_i),
      .desc_done_i(desc_done_i), .desc_eof_i(desc_eof_i), .packet_done_i(packet_done_i),
      .run_stop_o(run_stop_o), .halted_o(halted_o), .soft_reset_o(soft_reset_o),
      .cur_desc_o(cur_desc_o), .irq_o(irq_o));

   smeis_status #(.DESC_MODE(1'b0)) u_smeis_status_simple (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
      .rd_i(rd_i), .rd_data_o(rd_data_s), .fetch_dec_err_i(fetch_dec_err_i),
      .fetch_err_addr_i(fetch_err_addr_i), .engine_idle_i(engine_idle_i),
      .desc_done_i(desc_done_i), .desc_eof_i(desc_eof_i), .packet_done_i(packet_done_i),
      .run_stop_o(), .halted_o(), .soft_reset_o(), .cur_desc_o(), .irq_o());

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand for one cycle only, so they are taken mid-cycle
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      rd_d = rd_data_o;
      rd_s = rd_data_s;
   endtask

   // one-cycle event pulse: {decode error, desc done, eof, packet done}
   task automatic ev(input logic [3:0] v, input logic [31:0] a);
      @(posedge clk_i);
      {fetch_dec_err_i, desc_done_i, desc_eof_i, packet_done_i} <= v;
      fetch_err_addr_i <= a;
      @(posedge clk_i);
      {fetch_dec_err_i, desc_done_i, desc_eof_i, packet_done_i} <= 4'h0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      settle(0);
      chk("halted", {31'h0, halted_o}, 32'h1);
      chk("irq", {31'h0, irq_o}, 32'h0);
      rd(OFS_STATUS);
      chk("status", rd_d & 32'h0000FFFD, 32'h00000001);
      rd(OFS_CONTROL);
      chk("control", rd_d, 32'h00010000);
      rd(8'h0C);
      chk("unmapped", rd_d, 32'h00000000);
      $display("test reset done");
   endtask

   task automatic t_complete;
      wr(OFS_CONTROL, 32'h00011001);
      ev(4'b0001, 32'h0);
      rd(OFS_STATUS);
      chk("simple flag", rd_s & 32'h1000, 32'h1000);
      wr(OFS_STATUS, 32'h00001000);
      ev(4'b0100, 32'h0);
      rd(OFS_STATUS);
      chk("no eof flag", rd_d & 32'h1000, 32'h0);
      ev(4'b0110, 32'h0);
      settle(2);
      chk("irq eof", {31'h0, irq_o}, 32'h1);
      rd(OFS_STATUS);
      chk("eof flag", rd_d & 32'h1000, 32'h1000);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS);
      chk("flag after 0", rd_d & 32'h1000, 32'h1000);
      chk("irq held", {31'h0, irq_o}, 32'h1);
      wr(OFS_STATUS, 32'h00001000);
      settle(2);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
      rd(OFS_STATUS);
      chk("flag cleared", rd_d & 32'h1000, 32'h0);
      // threshold of two: first completion alone must not interrupt
      wr(OFS_CONTROL, 32'h00021001);
      ev(4'b0110, 32'h0);
      settle(2);
      chk("irq below thr", {31'h0, irq_o}, 32'h0);
      ev(4'b0110, 32'h0);
      settle(2);
      chk("irq at thr", {31'h0, irq_o}, 32'h1);
      wr(OFS_STATUS, 32'h00001000);
      wr(OFS_CONTROL, 32'h00010001);
      ev(4'b0110, 32'h0);
      settle(2);
      chk("irq disabled", {31'h0, irq_o}, 32'h0);
      wr(OFS_STATUS, 32'h00001000);
      $display("test completion done");
   endtask

   task automatic t_decode_err;
      int i;
      chk("running", {31'h0, run_stop_o}, 32'h1);
      ev(4'b1000, 32'h12345678);
      settle(0);
      chk("stop on err", {31'h0, run_stop_o}, 32'h0);
      chk("err pointer", cur_desc_o, 32'h12345640);
      chk("not halted", {31'h0, halted_o}, 32'h0);
      rd(OFS_STATUS);
      chk("err bit", rd_d & 32'h0C00, 32'h0400);
      chk("simple err", rd_s & 32'h0C00, 32'h0);
      @(posedge clk_i);
      engine_idle_i <= 1'b1;
      i = 0;
      while (halted_o !== 1'b1 && i < 8) begin
         @(negedge clk_i);
         i++;
      end
      chk("halted", {31'h0, halted_o}, 32'h1);
      if (halted_o !== 1'b1) begin
         tally_and_finish;
      end
      ev(4'b1000, 32'hABCDEF00);
      settle(1);
      chk("first ptr kept", cur_desc_o, 32'h12345640);
      wr(OFS_CONTROL, 32'h00011001);
      wr(OFS_CUR_DESC, 32'h00000100);
      settle(1);
      chk("run refused", {31'h0, run_stop_o}, 32'h0);
      chk("ptr write refused", cur_desc_o, 32'h12345640);
      // write-to-clear must not reach the error bit, reserved bit stays zero
      wr(OFS_STATUS, 32'hFFFFFFFF);
      rd(OFS_STATUS);
      chk("err sticky", rd_d & 32'h0C00, 32'h0400);
      wr(OFS_CONTROL, 32'h00000004);
      settle(0);
      chk("soft pulse", {31'h0, soft_reset_o}, 32'h1);
      settle(1);
      chk("soft pulse end", {31'h0, soft_reset_o}, 32'h0);
      chk("ptr reset", cur_desc_o, 32'h0);
      rd(OFS_STATUS);
      chk("err cleared", rd_d & 32'h0C00, 32'h0);
      // halted with no error: the pointer takes a write, low bits masked
      wr(OFS_CUR_DESC, 32'h00000123);
      rd(OFS_CUR_DESC);
      chk("ptr write", rd_d, 32'h00000100);
      @(posedge clk_i);
      engine_idle_i <= 1'b0;
      wr(OFS_CONTROL, 32'h00010001);
      settle(1);
      chk("run again", {31'h0, run_stop_o}, 32'h1);
      $display("test decode error done");
   endtask

   task automatic t_hard_reset;
      ev(4'b1000, 32'h0000087F);
      rd(OFS_CUR_DESC);
      chk("err ptr read", rd_d, 32'h00000840);
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      settle(0);
      chk("ptr hard reset", cur_desc_o, 32'h0);
      chk("halted hard reset", {31'h0, halted_o}, 32'h1);
      chk("run hard reset", {31'h0, run_stop_o}, 32'h0);
      rd(OFS_STATUS);
      chk("err hard reset", rd_d & 32'h0C00, 32'h0);
      $display("test hard reset done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wr_data_i = 32'h0;
      fetch_dec_err_i = 1'b0;
      fetch_err_addr_i = 32'h0;
      engine_idle_i = 1'b0;
      desc_done_i = 1'b0;
      desc_eof_i = 1'b0;
      packet_done_i = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_complete;
      t_decode_err;
      t_hard_reset;
      tally_and_finish;
   end
endmodule
